//--- hw/brt_map.vh
`ifndef BRT_MAP_VH
`define BRT_MAP_VH
// ==========================================
// Clock and timing
`define BRT_CLK_MHZ        100
`define BRT_DROP_DELAY_US  5
`define BRT_DROP_CYCLES    (`BRT_DROP_DELAY_US * `BRT_CLK_MHZ)
`define BRT_CNT_W          10
// ==========================================
// Byte codes
`define BRT_CHAR_PLUS      8'h2B
`define BRT_CHAR_MINUS     8'h2D
`define BRT_CHAR_CR        8'h0D
`define BRT_DIGIT_HI       4'h3
// ==========================================
// Readout shape
`define BRT_MAX_DIGITS     16
`define BRT_DIGIT_W        4
`define BRT_NDIG_W         5
`define BRT_IDX_W          5
// ==========================================
// Addressing
`define BRT_DEV_TYPE       4'h6
`define BRT_ADDR_W         8
`endif

//--- hw/brt_readout_port.v
`timescale 1ns/10ps
`include "brt_map.vh"
module brt_readout_port (
	clk,
	rst,
	devAddr,
	hostType,
	hostAddr,
	hostEnable,
	hostReady,
	hostData,
	hostValid,
	hostAck,
	hostDataReady,
	instStrobe,
	instSign,
	instDigits,
	numDigits,
	instRequest
);
	input  wire                                      clk;
	input  wire                                      rst;
	input  wire [`BRT_ADDR_W-1:0]                    devAddr;
	input  wire [3:0]                                hostType;
	input  wire [`BRT_ADDR_W-1:0]                    hostAddr;
	input  wire                                      hostEnable;
	input  wire                                      hostReady;
	output reg  [7:0]                                hostData;
	output reg                                       hostValid;
	input  wire                                      hostAck;
	output reg                                       hostDataReady;
	input  wire                                      instStrobe;
	input  wire                                      instSign;
	input  wire [`BRT_MAX_DIGITS*`BRT_DIGIT_W-1:0]   instDigits;
	input  wire [`BRT_NDIG_W-1:0]                    numDigits;
	output reg                                       instRequest;

	localparam ST_IDLE  = 3'h0;
	localparam ST_REQ   = 3'h1;
	localparam ST_DELAY = 3'h2;
	localparam ST_SEND  = 3'h3;
	localparam ST_DRAIN = 3'h4;
	localparam ST_WAIT  = 3'h5;
	localparam [`BRT_CNT_W-1:0] DROP_LAST = `BRT_DROP_CYCLES - 1;
	localparam [`BRT_NDIG_W-1:0] NDIG_MAX = `BRT_MAX_DIGITS;

	// ==========================================
	// Byte formatting
	function [7:0] brtDigitChar;
		input [`BRT_DIGIT_W-1:0] code;
		begin
			brtDigitChar = {`BRT_DIGIT_HI, code};
		end
	endfunction

	// ==========================================
	// Pin synchronisers
	reg [2:0] strobeSync_r;
	reg [2:0] signSync_r;
	reg       strobeLvl_r;
	reg       strobePrev_r;
	reg       signLvl_r;
	always @(posedge clk) begin
		if (rst) begin
			strobeSync_r <= 3'h0;
			signSync_r   <= 3'h0;
			strobeLvl_r  <= 1'b0;
			strobePrev_r <= 1'b0;
			signLvl_r    <= 1'b0;
		end else begin
			strobeSync_r <= {strobeSync_r[1:0], instStrobe};
			signSync_r   <= {signSync_r[1:0], instSign};
			if (strobeSync_r[1] == strobeSync_r[2]) begin
				strobeLvl_r <= strobeSync_r[2];
			end
			if (signSync_r[1] == signSync_r[2]) begin
				signLvl_r <= signSync_r[2];
			end
			strobePrev_r <= strobeLvl_r;
		end
	end
	wire strobeRise = strobeLvl_r & ~strobePrev_r;

	// ==========================================
	// Address match
	wire selected = (hostType == `BRT_DEV_TYPE) && (hostAddr == devAddr);
	wire enabled  = selected && hostEnable;

	// ==========================================
	// Readout capture and sequencing
	reg [2:0]                                state_r;
	reg [2:0]                                state_nxt;
	reg [`BRT_CNT_W-1:0]                     delayCnt_r;
	reg [`BRT_MAX_DIGITS*`BRT_DIGIT_W-1:0]   digits_r;
	reg                                      sign_r;
	reg [`BRT_NDIG_W-1:0]                    nDig_r;
	reg [`BRT_IDX_W:0]                       idx_r;
	reg                                      pushValid;
	reg [7:0]                                pushData;
	wire                                     pushReady;
	wire [7:0]                               bufData;
	wire                                     bufValid;
	wire                                     bufEmpty;
	wire                                     bufPop;
	wire                                     lastByte;
	wire [`BRT_IDX_W-1:0]                    digIdx;

	assign digIdx   = idx_r[`BRT_IDX_W-1:0] - {{(`BRT_IDX_W-1){1'b0}}, 1'b1};
	assign lastByte = (idx_r == {1'b0, nDig_r} + {{`BRT_IDX_W{1'b0}}, 1'b1});

	always @* begin
		pushData = `BRT_CHAR_CR;
		if (idx_r == {(`BRT_IDX_W+1){1'b0}}) begin
			pushData = sign_r ? `BRT_CHAR_PLUS : `BRT_CHAR_MINUS;
		end else if (!lastByte) begin
			pushData = brtDigitChar(digits_r[digIdx*`BRT_DIGIT_W +: `BRT_DIGIT_W]);
		end else begin
			pushData = `BRT_CHAR_CR;
		end
	end

	always @* begin
		pushValid = (state_r == ST_SEND);
		state_nxt = state_r;
		case (state_r)
			ST_IDLE:  if (enabled) state_nxt = ST_REQ;
			ST_REQ:   if (strobeRise) state_nxt = ST_DELAY;
			ST_DELAY: if (delayCnt_r == DROP_LAST) state_nxt = ST_SEND;
			ST_SEND:  if (pushReady && lastByte) state_nxt = ST_DRAIN;
			ST_DRAIN: if (bufEmpty && !hostValid) state_nxt = ST_WAIT;
			ST_WAIT:  if (hostReady && enabled) state_nxt = ST_REQ;
			default:  state_nxt = ST_IDLE;
		endcase
	end

	always @(posedge clk) begin
		if (rst) begin
			state_r     <= ST_IDLE;
			delayCnt_r  <= {`BRT_CNT_W{1'b0}};
			digits_r    <= {(`BRT_MAX_DIGITS*`BRT_DIGIT_W){1'b0}};
			sign_r      <= 1'b0;
			nDig_r      <= {`BRT_NDIG_W{1'b0}};
			idx_r       <= {(`BRT_IDX_W+1){1'b0}};
			instRequest <= 1'b0;
		end else begin
			state_r <= state_nxt;
			if (state_r == ST_REQ && strobeRise) begin
				digits_r <= instDigits;
				sign_r   <= signLvl_r;
				nDig_r   <= (numDigits > NDIG_MAX) ? NDIG_MAX : numDigits;
				idx_r    <= {(`BRT_IDX_W+1){1'b0}};
			end
			delayCnt_r <= (state_r == ST_DELAY) ? delayCnt_r + {{(`BRT_CNT_W-1){1'b0}}, 1'b1}
				: {`BRT_CNT_W{1'b0}};
			if (pushValid && pushReady) begin
				idx_r <= idx_r + {{`BRT_IDX_W{1'b0}}, 1'b1};
			end
			instRequest <= (state_nxt == ST_REQ) || (state_nxt == ST_DELAY);
		end
	end

	// ==========================================
	// Output buffer and host register stage
	brt_skid_buffer #(
		.WIDTH(8)
	) uBuf (
		.clk      (clk),
		.rst      (rst),
		.inData   (pushData),
		.inValid  (pushValid),
		.inReady  (pushReady),
		.outData  (bufData),
		.outValid (bufValid),
		.outReady (bufPop)
	);
	assign bufEmpty = ~bufValid;
	assign bufPop   = bufValid && (!hostValid || hostAck);

	always @(posedge clk) begin
		if (rst) begin
			hostData      <= 8'h00;
			hostValid     <= 1'b0;
			hostDataReady <= 1'b0;
		end else begin
			if (bufPop) begin
				hostData  <= bufData;
				hostValid <= 1'b1;
			end else if (hostAck) begin
				hostValid <= 1'b0;
			end
			hostDataReady <= (state_nxt == ST_SEND) || (state_nxt == ST_DRAIN);
		end
	end
endmodule // brt_readout_port

//--- hw/brt_skid_buffer.v
`timescale 1ns/10ps
// ==========================================
// Two-entry buffer
module brt_skid_buffer #(
	parameter WIDTH = 8
) (
	input  wire             clk,
	input  wire             rst,
	input  wire [WIDTH-1:0] inData,
	input  wire             inValid,
	output wire             inReady,
	output wire [WIDTH-1:0] outData,
	output wire             outValid,
	input  wire             outReady
);
	reg [WIDTH-1:0] mem_r [0:1];
	reg             wrPtr_r;
	reg             rdPtr_r;
	reg [1:0]       count_r;
	wire            doPush;
	wire            doPop;

	assign inReady  = (count_r != 2'h2);
	assign outValid = (count_r != 2'h0);
	assign outData  = mem_r[rdPtr_r];
	assign doPush   = inValid && inReady;
	assign doPop    = outValid && outReady;

	always @(posedge clk) begin
		if (doPush) begin
			mem_r[wrPtr_r] <= inData;
		end
	end

	always @(posedge clk) begin
		if (rst) begin
			wrPtr_r <= 1'b0;
			rdPtr_r <= 1'b0;
			count_r <= 2'h0;
		end else begin
			if (doPush) begin
				wrPtr_r <= ~wrPtr_r;
			end
			if (doPop) begin
				rdPtr_r <= ~rdPtr_r;
			end
			case ({doPush, doPop})
				2'b10: count_r <= count_r + 2'h1;
				2'b01: count_r <= count_r - 2'h1;
				default: count_r <= count_r;
			endcase
		end
	end
endmodule // brt_skid_buffer

//--- verif/brt_inst_model.sv
`timescale 1ns/10ps
// ==========================================
// Instrument side
module brt_inst_model (
	input  logic       clk,
	input  logic       instRequest,
	input  logic [7:0] dly,
	output logic       instStrobe
);
	initial begin
		instStrobe = 1'b0;
		forever begin
			@(negedge clk);
			if (instRequest === 1'b1) begin
				repeat (dly) @(negedge clk);
				instStrobe = 1'b1;
				repeat (8) @(negedge clk);
				instStrobe = 1'b0;
				while (instRequest === 1'b1) @(negedge clk);
			end
		end
	end
endmodule // brt_inst_model

//--- verif/brt_port_asserts.sv
`timescale 1ns/10ps
// ==========================================
// Port checks
module brt_port_asserts (
	input logic       clk,
	input logic       rst,
	input logic [7:0] devAddr,
	input logic [3:0] hostType,
	input logic [7:0] hostAddr,
	input logic       hostEnable,
	input logic       hostReady,
	input logic [7:0] hostData,
	input logic       hostValid,
	input logic       hostAck,
	input logic       hostDataReady,
	input logic       instStrobe,
	input logic       instRequest
);
	logic [9:0] sinceStb_r;
	wire        sel = hostType == 4'h6 && hostAddr == devAddr;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	always @(posedge clk) begin
		if (rst || $rose(instStrobe)) sinceStb_r <= 10'h000;
		else if (sinceStb_r != 10'h3FF) sinceStb_r <= sinceStb_r + 10'h001;
	end
	property p_rstQuiet;
		disable iff (1'b0) rst |=> !instRequest && !hostValid && !hostDataReady;
	endproperty
	a_rstQuiet: assert property (p_rstQuiet) else $error("busy after reset");
	property p_hold;
		hostValid && !hostAck |=> hostValid && $stable(hostData);
	endproperty
	a_hold: assert property (p_hold) else $error("byte lost");
	property p_lowSend;
		hostDataReady |-> !instRequest;
	endproperty
	a_lowSend: assert property (p_lowSend) else $error("request during send");
	property p_crEnd;
		hostValid && hostAck && hostData == 8'h0D |=> ##[0:1] !hostDataReady;
	endproperty
	a_crEnd: assert property (p_crEnd) else $error("no end after return");
	property p_ascii;
		hostValid |-> hostData[7:4] == 4'h3 || hostData inside {8'h2B, 8'h2D, 8'h0D};
	endproperty
	a_ascii: assert property (p_ascii) else $error("bad byte");
	property p_dropWin;
		$fell(instRequest) |-> sinceStb_r >= 10'h1F4 && sinceStb_r <= 10'h200;
	endproperty
	a_dropWin: assert property (p_dropWin) else $error("drop timing");
	property p_signFirst;
		$rose(hostDataReady) |-> ##[0:4] hostValid && hostData inside {8'h2B, 8'h2D};
	endproperty
	a_signFirst: assert property (p_signFirst) else $error("sign not first");
	property p_raise;
		sel && hostEnable && hostReady && !hostValid && !hostDataReady |-> ##[1:2] instRequest;
	endproperty
	a_raise: assert property (p_raise) else $error("no request");
endmodule // brt_port_asserts

bind brt_readout_port brt_port_asserts brt_port_asserts_inst (.clk(clk), .rst(rst),
	.devAddr(devAddr), .hostType(hostType), .hostAddr(hostAddr), .hostEnable(hostEnable),
	.hostReady(hostReady), .hostData(hostData), .hostValid(hostValid), .hostAck(hostAck),
	.hostDataReady(hostDataReady), .instStrobe(instStrobe), .instRequest(instRequest));

//--- verif/brt_tb.sv
`timescale 1ns/10ps
// ==========================================
// Bench
module tb;
	logic        clk = 1'b0, rst = 1'b1, hostEnable = 1'b0, hostReady = 1'b0;
	logic        hostAck = 1'b0, instSign = 1'b1, instStrobe, instRequest, hostValid;
	logic        hostDataReady;
	logic [3:0]  hostType = 4'h6;
	logic [7:0]  devAddr = 8'h5A, hostAddr = 8'h5B, hostData, dly = 8'h3C;
	logic [63:0] instDigits = 64'hF987654321098765;
	logic [4:0]  numDigits = 5'h10;
	integer      err_count = 0, n_compared = 0;
	always #5 clk = ~clk;
	brt_readout_port brt_readout_port_inst (.clk(clk), .rst(rst), .devAddr(devAddr),
		.hostType(hostType), .hostAddr(hostAddr), .hostEnable(hostEnable),
		.hostReady(hostReady), .hostData(hostData), .hostValid(hostValid), .hostAck(hostAck),
		.hostDataReady(hostDataReady), .instStrobe(instStrobe), .instSign(instSign),
		.instDigits(instDigits), .numDigits(numDigits), .instRequest(instRequest));
	brt_inst_model brt_inst_model_inst (.clk(clk), .instRequest(instRequest), .dly(dly),
		.instStrobe(instStrobe));
	task end_sim;
		$display("errors %0d compared %0d", err_count, n_compared);
		if (err_count == 0 && n_compared > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task take(input logic [7:0] exp, input integer stall);
		integer i;
		i = 0;
		do begin
			@(negedge clk);
			i++;
		end while (hostValid !== 1'b1 && i < 2000);
		if (hostValid !== 1'b1) begin
			err_count++;
			$display("wrong value at %0t: no byte", $time);
			end_sim;
		end
		repeat (stall) @(negedge clk);
		chk(hostData, exp);
		hostAck = 1'b1;
		@(negedge clk);
		hostAck = 1'b0;
	endtask
	task ro(input logic sgn, input logic [4:0] nd, input integer stall);
		integer k;
		instSign = sgn;
		numDigits = nd;
		take(sgn ? 8'h2B : 8'h2D, stall);
		chk({7'h00, instRequest}, 8'h00);
		for (k = 0; k < nd; k++) take({4'h3, instDigits[4*k +: 4]}, stall);
		take(8'h0D, stall);
		hostEnable = 1'b1;
		hostReady = 1'b1;
		repeat (3) @(negedge clk);
		chk({7'h00, instRequest}, 8'h01);
		hostReady = 1'b0;
	endtask
	initial begin
		repeat (4) @(negedge clk);
		rst = 1'b0;
		chk(hostData, 8'h00);
		chk({6'h00, hostValid, hostDataReady}, 8'h00);
		hostEnable = 1'b1;
		hostReady = 1'b1;
		repeat (20) @(negedge clk);
		chk({7'h00, instRequest}, 8'h00);
		hostAddr = 8'h5A;
		repeat (3) @(negedge clk);
		chk({7'h00, instRequest}, 8'h01);
		hostReady = 1'b0;
		hostEnable = 1'b0;
		repeat (20) @(negedge clk);
		chk({7'h00, instRequest}, 8'h01);
		ro(1'b1, 5'h10, 0);
		dly = 8'h02;
		ro(1'b0, 5'h00, 3);
		ro(1'b1, 5'h03, 1);
		end_sim;
	end
endmodule // tb
